/* core/prsl_remap_fabric.sv */
// Peripheral pin remap fabric with lock, key sequence and shadow monitor
////////////////////////////////////////////////////////////////////////////////
//
// The placing of the registers and the strobed register port were decided locally.
module prsl_remap_fabric
	import prsl_pkg::*;
#(
	parameter logic [PRSL_NUM_PINS-1:0] PIN_PRESENT = {PRSL_NUM_PINS{1'b1}},
	parameter logic SINGLE_SESSION_DEFAULT = 1'b1
)(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [PRSL_ADDR_W-1:0] reg_addr,
	input wire logic [PRSL_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [PRSL_DATA_W-1:0] reg_rdata,
	input wire logic single_session_option,
	input wire logic [PRSL_NUM_PINS-1:0] pin_in,
	input wire logic [PRSL_NUM_PINS-1:0] pin_analog,
	input wire logic [PRSL_NUM_FUNCS-1:0] periph_out,
	output logic [PRSL_NUM_IN-1:0] periph_in,
	output logic [PRSL_NUM_IO-1:0] pin_out,
	output logic [PRSL_NUM_IO-1:0] pin_out_sel,
	output logic map_write_lock,
	output logic config_mismatch_reset
);

	////////////////////////////////////////////////////////////////////////////
	logic [PRSL_SEL_W-1:0] in_sel_q [PRSL_NUM_IN];
	logic [PRSL_SEL_W-1:0] in_sel_d [PRSL_NUM_IN];
	logic [PRSL_SEL_W-1:0] in_shadow_q [PRSL_NUM_IN];
	logic [PRSL_SEL_W-1:0] out_sel_q [PRSL_NUM_IO];
	logic [PRSL_SEL_W-1:0] out_sel_d [PRSL_NUM_IO];
	logic [PRSL_SEL_W-1:0] out_shadow_q [PRSL_NUM_IO];
	logic lock_q, lock_d;
	logic one_way_q, one_way_d;
	logic strap_taken_q, strap_taken_d;
	prsl_key_e key_q, key_d;
	logic [PRSL_DATA_W-1:0] rdata_q, rdata_d;
	logic mismatch_q, mismatch_d;
	logic [PRSL_NUM_PINS-1:0] pin_s1_q, pin_s2_q;
	logic [PRSL_NUM_PINS-1:0] ana_s1_q, ana_s2_q;
	logic opt_s1_q, opt_s2_q;
	logic [PRSL_NUM_IN-1:0] periph_in_q, periph_in_d;
	logic [PRSL_NUM_IO-1:0] pin_out_q, pin_out_d;
	logic [PRSL_NUM_IO-1:0] pin_out_sel_q, pin_out_sel_d;
	logic is_in_reg, is_out_reg, is_osc;
	logic [4:0] reg_idx;

	assign reg_idx = reg_addr[4:0];
	assign is_in_reg = (reg_addr[7:5] == PRSL_IN_SEL_BASE[7:5]) && (reg_idx < 5'(PRSL_NUM_IN_REGS));
	assign is_out_reg = (reg_addr[7:5] == PRSL_OUT_SEL_BASE[7:5]) && (reg_idx < 5'(PRSL_NUM_OUT_REGS));
	assign is_osc = (reg_addr == PRSL_OSC_CTRL_ADDR);

	////////////////////////////////////////////////////////////////////////////
	// Lock, key sequence and strap capture
	always_comb begin
		key_d = key_q;
		lock_d = lock_q;
		one_way_d = one_way_q;
		strap_taken_d = 1'b1;
		// Option is caught once after reset release, never inside reset
		if (!strap_taken_q) begin
			one_way_d = opt_s2_q;
		end
		if (reg_wr) begin
			key_d = PRSL_KEY_IDLE;
			if (is_osc) begin
				case (key_q)
					PRSL_KEY_IDLE: begin
						if (reg_wdata[7:0] == PRSL_KEY_ONE) begin
							key_d = PRSL_KEY_GOT1;
						end
					end
					PRSL_KEY_GOT1: begin
						if (reg_wdata[7:0] == PRSL_KEY_TWO) begin
							key_d = PRSL_KEY_OPEN;
						end else if (reg_wdata[7:0] == PRSL_KEY_ONE) begin
							key_d = PRSL_KEY_GOT1;
						end
					end
					PRSL_KEY_OPEN: begin
						// A set lock with the single session option stays set
						if (!(lock_q && one_way_q)) begin
							lock_d = reg_wdata[PRSL_LOCK_BIT];
						end
					end
					default: key_d = PRSL_KEY_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			key_q <= PRSL_KEY_IDLE;
			lock_q <= PRSL_LOCK_RESET;
			one_way_q <= SINGLE_SESSION_DEFAULT;
			strap_taken_q <= 1'b0;
		end else begin
			key_q <= key_d;
			lock_q <= lock_d;
			one_way_q <= one_way_d;
			strap_taken_q <= strap_taken_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Select registers with shadow copies
	always_comb begin
		for (int i = 0; i < PRSL_NUM_IN; i++) begin
			in_sel_d[i] = in_sel_q[i];
		end
		for (int i = 0; i < PRSL_NUM_IO; i++) begin
			out_sel_d[i] = out_sel_q[i];
		end
		if (reg_wr && !lock_q) begin
			if (is_in_reg) begin
				in_sel_d[2*reg_idx] = reg_wdata[PRSL_LO_FIELD_LSB +: PRSL_SEL_W];
				if (2*reg_idx+1 < PRSL_NUM_IN) begin
					in_sel_d[2*reg_idx+1] = reg_wdata[PRSL_HI_FIELD_LSB +: PRSL_SEL_W];
				end
			end
			if (is_out_reg) begin
				// Missing pins keep null, so writes to them do nothing
				if (PIN_PRESENT[2*reg_idx]) begin
					out_sel_d[2*reg_idx] = reg_wdata[PRSL_LO_FIELD_LSB +: PRSL_SEL_W];
				end
				if (PIN_PRESENT[2*reg_idx+1]) begin
					out_sel_d[2*reg_idx+1] = reg_wdata[PRSL_HI_FIELD_LSB +: PRSL_SEL_W];
				end
			end
		end
		mismatch_d = mismatch_q;
		for (int i = 0; i < PRSL_NUM_IN; i++) begin
			if (in_sel_q[i] != in_shadow_q[i]) begin
				mismatch_d = 1'b1;
			end
		end
		for (int i = 0; i < PRSL_NUM_IO; i++) begin
			if (out_sel_q[i] != out_shadow_q[i]) begin
				mismatch_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < PRSL_NUM_IN; i++) begin
				in_sel_q[i] <= PRSL_IN_SEL_RESET;
				in_shadow_q[i] <= PRSL_IN_SEL_RESET;
			end
			for (int i = 0; i < PRSL_NUM_IO; i++) begin
				out_sel_q[i] <= PRSL_OUT_SEL_RESET;
				out_shadow_q[i] <= PRSL_OUT_SEL_RESET;
			end
			mismatch_q <= 1'b0;
		end else begin
			// Shadows load from the same next value; only a disturbed cell diverges
			for (int i = 0; i < PRSL_NUM_IN; i++) begin
				in_sel_q[i] <= in_sel_d[i];
				in_shadow_q[i] <= in_sel_d[i];
			end
			for (int i = 0; i < PRSL_NUM_IO; i++) begin
				out_sel_q[i] <= out_sel_d[i];
				out_shadow_q[i] <= out_sel_d[i];
			end
			mismatch_q <= mismatch_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			if (is_in_reg) begin
				rdata_d[PRSL_LO_FIELD_LSB +: PRSL_SEL_W] = in_sel_q[2*reg_idx];
				if (2*reg_idx+1 < PRSL_NUM_IN) begin
					rdata_d[PRSL_HI_FIELD_LSB +: PRSL_SEL_W] = in_sel_q[2*reg_idx+1];
				end
			end else if (is_out_reg) begin
				rdata_d[PRSL_LO_FIELD_LSB +: PRSL_SEL_W] = out_sel_q[2*reg_idx];
				rdata_d[PRSL_HI_FIELD_LSB +: PRSL_SEL_W] = out_sel_q[2*reg_idx+1];
			end else if (is_osc) begin
				rdata_d[PRSL_LOCK_BIT] = lock_q;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			ana_s1_q <= '0;
			ana_s2_q <= '0;
		end else begin
			rdata_q <= rdata_d;
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
			ana_s1_q <= pin_analog;
			ana_s2_q <= ana_s1_q;
		end
	end

	// Option synchroniser runs through reset, so the level is settled when it is caught
	always_ff @(posedge core_clk) begin
		opt_s1_q <= single_session_option;
		opt_s2_q <= opt_s1_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Routing; the fabric only steers signals, enables stay with each peripheral
	always_comb begin
		for (int i = 0; i < PRSL_NUM_IN; i++) begin
			periph_in_d[i] = 1'b0;
			// Invalid or absent pin and analog pins give a grounded input
			if (in_sel_q[i] <= PRSL_LAST_VALID_PIN) begin
				if (PIN_PRESENT[in_sel_q[i]] && !ana_s2_q[in_sel_q[i]]) begin
					periph_in_d[i] = pin_s2_q[in_sel_q[i]];
				end
			end
		end
		for (int p = 0; p < PRSL_NUM_IO; p++) begin
			pin_out_d[p] = 1'b0;
			pin_out_sel_d[p] = 1'b0;
			if (out_sel_q[p] != PRSL_OUT_SEL_RESET && out_sel_q[p] <= PRSL_LAST_FUNC
				&& !ana_s2_q[p]) begin
				pin_out_sel_d[p] = 1'b1;
				pin_out_d[p] = periph_out[out_sel_q[p]];
			end
		end
	end

	// Routed data leave from flops, one cycle behind the selects, so a pad never glitches
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			periph_in_q <= '0;
			pin_out_q <= '0;
			pin_out_sel_q <= '0;
		end else begin
			periph_in_q <= periph_in_d;
			pin_out_q <= pin_out_d;
			pin_out_sel_q <= pin_out_sel_d;
		end
	end

	assign periph_in = periph_in_q;
	assign pin_out = pin_out_q;
	assign pin_out_sel = pin_out_sel_q;
	assign reg_rdata = rdata_q;
	assign map_write_lock = lock_q;
	assign config_mismatch_reset = mismatch_q;
endmodule

/* core/prsl_pkg.sv */
// Package with register map, field layout and reset values of the pin remap fabric
package prsl_pkg;
	localparam int PRSL_SEL_W = 6;
	localparam int PRSL_ADDR_W = 8;
	localparam int PRSL_DATA_W = 16;
	localparam int PRSL_NUM_IN = 36;
	localparam int PRSL_NUM_IO = 32;
	localparam int PRSL_NUM_PINS = 44;
	localparam int PRSL_NUM_IN_REGS = 18;
	localparam int PRSL_NUM_OUT_REGS = 16;
	localparam int PRSL_NUM_FUNCS = 37;
	// Register indices: input selects, then output selects, then oscillator control
	localparam logic [7:0] PRSL_IN_SEL_BASE = 8'h00;
	localparam logic [7:0] PRSL_OUT_SEL_BASE = 8'h20;
	localparam logic [7:0] PRSL_OSC_CTRL_ADDR = 8'h40;
	// Field layout within the 16-bit select and oscillator control registers
	localparam int PRSL_LO_FIELD_LSB = 0;
	localparam int PRSL_HI_FIELD_LSB = 8;
	localparam int PRSL_LOCK_BIT = 6;
	localparam logic [7:0] PRSL_KEY_ONE = 8'h46;
	localparam logic [7:0] PRSL_KEY_TWO = 8'h57;
	localparam logic [5:0] PRSL_IN_SEL_RESET = 6'h3f;
	localparam logic [5:0] PRSL_OUT_SEL_RESET = 6'h00;
	localparam logic [5:0] PRSL_LAST_VALID_PIN = 6'h2b;
	localparam logic [5:0] PRSL_LAST_FUNC = 6'h24;
	localparam logic PRSL_LOCK_RESET = 1'b0;
	typedef enum logic [2:0] {
		PRSL_KEY_IDLE = 3'b001,
		PRSL_KEY_GOT1 = 3'b010,
		PRSL_KEY_OPEN = 3'b100
	} prsl_key_e;
endpackage

/* testbench/prsl_checker.sv */
// Checker of read port, lock and key sequence of the remap fabric
module prsl_checker
	import prsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [PRSL_ADDR_W-1:0] reg_addr,
	input wire logic [PRSL_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [PRSL_DATA_W-1:0] reg_rdata,
	input wire logic single_session_option,
	input wire logic [PRSL_NUM_IO-1:0] pin_out_sel,
	input wire logic map_write_lock,
	input wire logic config_mismatch_reset
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
	a_lock_cause: assert property ($changed(map_write_lock) |-> $past(reg_wr))
		else $error("lock moved without a write");
	a_lock_keys: assert property ($rose(map_write_lock) |->
		$past(reg_wdata[7:0], 2) == 8'h57 && $past(reg_wdata[7:0], 3) == 8'h46)
		else $error("lock set without both keys");
	a_one_session: assert property ($past(map_write_lock) && single_session_option |->
		map_write_lock) else $error("lock cleared in single session");
	a_no_mismatch: assert property (!config_mismatch_reset)
		else $error("mismatch reset without corruption");
	a_sel_reset: assert property ($past(rst) |-> pin_out_sel == 32'h0)
		else $error("output selected after reset");
	a_locked_write: assert property (reg_wr && map_write_lock && !reg_addr[6] |=>
		$stable(pin_out_sel)) else $error("locked write changed outputs");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h40 |=> reg_rdata == 0)
		else $error("unmapped read not zero");
endmodule

/* testbench/prsl_far_model.sv */
// Far side model: peripherals driving outputs and board pins driving levels
module prsl_far_model
	import prsl_pkg::*;
(
	input wire logic core_clk,
	input wire logic [PRSL_NUM_FUNCS-1:0] func_en,
	input wire logic [PRSL_NUM_PINS-1:0] pin_level,
	output logic [PRSL_NUM_FUNCS-1:0] periph_out,
	output logic [PRSL_NUM_PINS-1:0] pin_in
);
	// A peripheral drives only when enabled on its own side; null code stays low
	always_ff @(posedge core_clk) begin
		periph_out <= func_en & {{(PRSL_NUM_FUNCS-1){1'b1}}, 1'b0};
		pin_in <= pin_level;
	end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench of the pin remap fabric
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top import prsl_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, opt = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
	logic [43:0] pin_level = '0, pin_analog = '0, pin_in;
	logic [36:0] func_en = '0, periph_out;
	logic [35:0] periph_in;
	logic [31:0] pin_out, pin_out_sel;
	logic map_write_lock, config_mismatch_reset;
	int errors = 0, tests_run = 0, cycles = 0;
	always #10 core_clk = ~core_clk;
	prsl_far_model far_u (.core_clk(core_clk), .func_en(func_en), .pin_level(pin_level),
		.periph_out(periph_out), .pin_in(pin_in));
	prsl_remap_fabric dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.single_session_option(opt), .pin_in(pin_in), .pin_analog(pin_analog),
		.periph_out(periph_out), .periph_in(periph_in), .pin_out(pin_out),
		.pin_out_sel(pin_out_sel), .map_write_lock(map_write_lock),
		.config_mismatch_reset(config_mismatch_reset));
	// Write strobe stays up so writes run back to back; idle drops it
	task wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
	endtask
	task idle(input int n);
		reg_wr <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask
	task rd(input logic [7:0] a);
		reg_addr <= a;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		@(posedge core_clk);
	endtask
	task keys(input logic [15:0] d);
		wr(PRSL_OSC_CTRL_ADDR, {8'h00, PRSL_KEY_ONE});
		wr(PRSL_OSC_CTRL_ADDR, {8'h00, PRSL_KEY_TWO});
		wr(PRSL_OSC_CTRL_ADDR, d);
		idle(2);
	endtask
	task summarize();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task test_reset();
		rd(8'h00);
		`CHK("in_reset", 16'h3f3f, rv)
		rd(8'h20);
		`CHK("out_reset", 16'h0000, rv)
		`CHK("sel_reset", 32'h0, pin_out_sel)
		`CHK("lock_reset", 1'b0, map_write_lock)
		rd(8'h50);
		`CHK("unmapped_rd", 16'h0000, rv)
		$display("reset test done");
	endtask
	task test_input();
		pin_level <= '1;
		pin_analog <= 44'h2;
		wr(8'h00, 16'h0000);
		wr(8'h01, 16'h3f2c);
		wr(8'h02, 16'h0100);
		idle(5);
		`CHK("in_shared", 2'b11, periph_in[1:0])
		`CHK("in_invalid", 2'b00, periph_in[3:2])
		`CHK("in_analog", 2'b01, periph_in[5:4])
		rd(8'h01);
		`CHK("in_field", 16'h3f2c, rv)
		$display("input test done");
	endtask
	// Pin 1 is analog, pin 2 carries an unused code, pins 0 and 3 share one function
	task test_output();
		func_en <= 37'h1 << 36;
		wr(8'h20, 16'h2424);
		wr(8'h21, 16'h2425);
		idle(3);
		`CHK("out_sel", 4'b1001, pin_out_sel[3:0])
		`CHK("out_level", 2'b11, {pin_out[3], pin_out[0]})
		`CHK("out_analog", 1'b0, pin_out[1])
		rd(8'h21);
		`CHK("out_field", 16'h2425, rv)
		$display("output test done");
	endtask
	task test_lock();
		wr(8'h40, 16'h0046);
		wr(8'h40, 16'h0099);
		wr(8'h40, 16'h0057);
		wr(8'h40, 16'h0040);
		idle(2);
		`CHK("key_abort", 1'b0, map_write_lock)
		keys(16'h0040);
		`CHK("lock_set", 1'b1, map_write_lock)
		rd(8'h40);
		`CHK("lock_read", 16'h0040, rv)
		wr(8'h00, 16'h0505);
		wr(8'h20, 16'h0000);
		idle(1);
		rd(8'h00);
		`CHK("locked_wr", 16'h0000, rv)
		`CHK("locked_out", 4'b1001, pin_out_sel[3:0])
		keys(16'h0000);
		`CHK("lock_kept", 1'b1, map_write_lock)
		$display("lock test done");
	endtask
	// Mid-run reset with the single session option off: the lock may be cleared again
	task test_session();
		opt <= 1'b0;
		rst <= 1'b1;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		test_reset();
		keys(16'h0040);
		`CHK("lock_again", 1'b1, map_write_lock)
		keys(16'h0000);
		`CHK("lock_cleared", 1'b0, map_write_lock)
		$display("session test done");
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		test_reset();
		test_input();
		test_output();
		test_lock();
		test_session();
		summarize();
	end
endmodule
bind prsl_remap_fabric prsl_checker chk_u (.core_clk(core_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .single_session_option(single_session_option),
	.pin_out_sel(pin_out_sel), .map_write_lock(map_write_lock),
	.config_mismatch_reset(config_mismatch_reset));
